/* core/rcs_pkg.sv */
/*
  Package for the reset cause and start-up block: register offsets, field positions,
  reset values and timing constants.
  Assumes a 100 MHz core clock.
*/
package rcs_pkg;

  // ************************************************************
  // register offsets (block-local address space)
  // ************************************************************
  localparam logic [1:0] RCS_ADDR_CAUSE   = 2'h0;
  localparam logic [1:0] RCS_ADDR_BORCTL  = 2'h1;
  localparam logic [1:0] RCS_ADDR_STATUS  = 2'h2;

  // ************************************************************
  // reset cause register fields
  // ************************************************************
  localparam int RCS_B_BOR  = 0;
  localparam int RCS_B_POR  = 1;
  localparam int RCS_B_RI   = 2;
  localparam int RCS_B_PIN  = 3;
  localparam int RCS_B_DOG  = 4;
  localparam int RCS_B_UNF  = 6;
  localparam int RCS_B_OVF  = 7;
  localparam logic [7:0] RCS_CAUSE_WMASK = 8'hdf;
  localparam logic [7:0] RCS_CAUSE_RST   = 8'h1c;

  // ************************************************************
  // status fields (timeout / power-down, both active low)
  // ************************************************************
  localparam int RCS_B_SLEEP = 3;
  localparam int RCS_B_TMO   = 4;
  localparam logic [7:0] RCS_STATUS_WMASK = 8'h07;

  // brown-out control: bits 7,6 writable, bit 0 ready
  localparam logic [7:0] RCS_BORCTL_WMASK = 8'hc0;
  localparam logic [7:0] RCS_BORCTL_RST   = 8'h80;

  // ************************************************************
  // program counter
  // ************************************************************
  localparam int          RCS_PC_W      = 15;
  localparam logic [14:0] RCS_PC_RESET  = 15'h0000;
  localparam logic [14:0] RCS_PC_VECTOR = 15'h0004;
  localparam logic [14:0] RCS_PC_ONE    = 15'h0001;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int RCS_CLK_MHZ       = 100;
  localparam int RCS_PWRUP_MS      = 64;
  localparam int RCS_PWRUP_CYC     = RCS_PWRUP_MS * 1000 * RCS_CLK_MHZ;
  localparam int RCS_PIN_REL_CYC   = 10;
  localparam int RCS_CNT_W         = 24;

endpackage : rcs_pkg

/* core/rcs_top.sv */
/*
  Reset cause and start-up sequencer: merges reset sources, runs the power-up
  delay and pin release, keeps cause flags, picks the restart program counter.
  Assumes all inputs except rstn are synchronous to core_clk; reset sources are pulses or
  levels from on-chip detectors; the core consumes core_rst_n and pc_load.
*/
`timescale 1ns/1ps
module rcs_top
  import rcs_pkg::*;
#(
  parameter int PWRUP_CYC = RCS_PWRUP_CYC
)(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                por_evt,
  input  wire logic                bor_evt,
  input  wire logic                low_power_brownout,
  input  wire logic                prog_exit,
  input  wire logic                ext_reset_pin,
  input  wire logic                ext_reset_enable,
  input  wire logic                powerup_delay_enable_n,
  input  wire logic                stack_fault_reset_enable,
  input  wire logic                dog_timeout,
  input  wire logic                soft_reset_instr,
  input  wire logic                stack_overflow,
  input  wire logic                stack_underflow,
  input  wire logic                sleeping,
  input  wire logic                wake_dog,
  input  wire logic                wake_irq,
  input  wire logic                global_irq_enable,
  input  wire logic                watchdog_clear_instr,
  input  wire logic                sleep_instr,
  input  wire logic                brownout_ready,
  input  wire logic [RCS_PC_W-1:0] cur_pc,
  input  wire logic [1:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     core_rst_n,
  output logic                     pc_load,
  output logic      [RCS_PC_W-1:0] pc_value,
  output logic                     push_return
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {RCS_HOLD, RCS_DELAY, RCS_RUN} rcs_phase_t;

  typedef struct packed {
    rcs_phase_t              phase;
    logic [RCS_CNT_W-1:0]    dly_cnt;
    logic                    dly_done;
    logic [3:0]              pin_cnt;
    logic [7:0]              cause;
    logic                    tmo_n;
    logic                    sleep_n;
    logic [2:0]              stat_low;
    logic [7:0]              borctl;
    logic [7:0]              rdata;
    logic                    run;
    logic                    pc_load;
    logic [RCS_PC_W-1:0]     pc;
    logic                    push;
  } rcs_state_t;

  rcs_state_t st_ff;
  rcs_state_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic       srst_n;

  // ************************************************************
  // reset release
  // ************************************************************
  // async assert, two-flop release so the core never sees a runt release
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign srst_n = rst_sync_ff[1];

  // ************************************************************
  // reset source decode
  // ************************************************************
  logic cold_evt;
  logic bo_evt;
  logic pin_low;
  logic stk_rst;
  logic warm_rst;

  assign cold_evt = por_evt | prog_exit;
  assign bo_evt   = bor_evt | low_power_brownout;
  assign pin_low  = ext_reset_enable & ~ext_reset_pin;
  assign stk_rst  = stack_fault_reset_enable & (stack_overflow | stack_underflow);
  assign warm_rst = dog_timeout | soft_reset_instr | stk_rst;

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.pc_load = 1'b0;
    nxt_st.push    = 1'b0;
    nxt_st.rdata   = 8'h00;

    // software access first so hardware events below win over it
    if (reg_wr)
    begin
      unique case (reg_addr)
        RCS_ADDR_CAUSE:
          nxt_st.cause = (st_ff.cause & ~RCS_CAUSE_WMASK) | (reg_wdata & RCS_CAUSE_WMASK);
        RCS_ADDR_BORCTL:
          nxt_st.borctl = (st_ff.borctl & ~RCS_BORCTL_WMASK) | (reg_wdata & RCS_BORCTL_WMASK);
        RCS_ADDR_STATUS:
          nxt_st.stat_low = reg_wdata[2:0];
        default:
          nxt_st.stat_low = st_ff.stat_low;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        RCS_ADDR_CAUSE:  nxt_st.rdata = st_ff.cause & RCS_CAUSE_WMASK;
        RCS_ADDR_BORCTL: nxt_st.rdata = {st_ff.borctl[7:6], 5'h00, brownout_ready};
        RCS_ADDR_STATUS: nxt_st.rdata = {3'h0, st_ff.tmo_n, st_ff.sleep_n, st_ff.stat_low};
        default:         nxt_st.rdata = 8'h00;
      endcase
    end

    // stack faults flag even when no reset follows
    if (stack_overflow)
      nxt_st.cause[RCS_B_OVF] = 1'b1;
    if (stack_underflow)
      nxt_st.cause[RCS_B_UNF] = 1'b1;
    if (watchdog_clear_instr)
    begin
      nxt_st.tmo_n   = 1'b1;
      nxt_st.sleep_n = 1'b1;
    end
    if (sleep_instr)
    begin
      nxt_st.tmo_n   = 1'b1;
      nxt_st.sleep_n = 1'b0;
    end

    // cause flags: warm causes change only their own bit; power-on reloads all, brown-out rewrites several
    if (cold_evt)
    begin
      nxt_st.cause   = RCS_CAUSE_RST;
      nxt_st.tmo_n   = 1'b1;
      nxt_st.sleep_n = 1'b1;
      nxt_st.borctl  = RCS_BORCTL_RST;
      nxt_st.stat_low = 3'h0;
    end
    else if (bo_evt)
    begin
      nxt_st.cause[RCS_B_OVF] = 1'b0;
      nxt_st.cause[RCS_B_UNF] = 1'b0;
      nxt_st.cause[RCS_B_DOG] = 1'b1;
      nxt_st.cause[RCS_B_PIN] = 1'b1;
      nxt_st.borctl           = RCS_BORCTL_RST;
      nxt_st.cause[RCS_B_BOR] = 1'b0;
      nxt_st.tmo_n            = 1'b1;
      nxt_st.sleep_n          = 1'b1;
    end
    else
    begin
      if (pin_low)
      begin
        nxt_st.cause[RCS_B_PIN] = 1'b0;
        if (sleeping)
        begin
          nxt_st.tmo_n   = 1'b1;
          nxt_st.sleep_n = 1'b0;
        end
      end
      if (dog_timeout && !sleeping)
      begin
        nxt_st.cause[RCS_B_DOG] = 1'b0;
        nxt_st.tmo_n            = 1'b0;
      end
      if (soft_reset_instr)
        nxt_st.cause[RCS_B_RI] = 1'b0;
      if (wake_dog && sleeping)
      begin
        nxt_st.tmo_n   = 1'b0;
        nxt_st.sleep_n = 1'b0;
      end
      else if (wake_irq && sleeping)
      begin
        nxt_st.tmo_n   = 1'b1;
        nxt_st.sleep_n = 1'b0;
      end
    end

    // start-up sequencing
    if (cold_evt || bo_evt)
    begin
      nxt_st.phase    = RCS_DELAY;
      nxt_st.dly_cnt  = '0;
      nxt_st.dly_done = powerup_delay_enable_n;
      nxt_st.pin_cnt  = 4'h0;
      nxt_st.run      = 1'b0;
    end
    else
    begin
      // delay keeps counting while the pin or a warm reset holds the core
      if (!st_ff.dly_done)
      begin
        if (st_ff.dly_cnt == RCS_CNT_W'(PWRUP_CYC - 1))
          nxt_st.dly_done = 1'b1;
        else
          nxt_st.dly_cnt = st_ff.dly_cnt + RCS_CNT_W'(1);
      end
      if (warm_rst || pin_low)
      begin
        nxt_st.phase   = RCS_HOLD;
        nxt_st.pin_cnt = 4'h0;
        nxt_st.run     = 1'b0;
      end
      else
      begin
        unique case (st_ff.phase)
          RCS_DELAY, RCS_HOLD:
          begin
            if (st_ff.dly_done)
            begin
              if (st_ff.pin_cnt == 4'(RCS_PIN_REL_CYC - 1))
              begin
                nxt_st.phase   = RCS_RUN;
                nxt_st.run     = 1'b1;
                nxt_st.pc_load = 1'b1;
                nxt_st.pc      = RCS_PC_RESET;
              end
              else
                nxt_st.pin_cnt = st_ff.pin_cnt + 4'h1;
            end
          end
          RCS_RUN:
          begin
            if (sleeping && (wake_dog || wake_irq))
            begin
              nxt_st.pc_load = 1'b1;
              nxt_st.pc      = cur_pc + RCS_PC_ONE;
              nxt_st.push    = wake_irq & global_irq_enable;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      st_ff          <= '0;
      st_ff.phase    <= RCS_HOLD;
      st_ff.dly_done <= 1'b1;
      st_ff.cause    <= RCS_CAUSE_RST;
      st_ff.tmo_n    <= 1'b1;
      st_ff.sleep_n  <= 1'b1;
      st_ff.borctl   <= RCS_BORCTL_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // interrupt wake with global enable: core pushes PC+1 then jumps to the vector
  assign core_rst_n  = st_ff.run;
  assign pc_load     = st_ff.pc_load;
  assign pc_value    = st_ff.push ? RCS_PC_VECTOR : st_ff.pc;
  assign push_return = st_ff.push;
  assign reg_rdata   = st_ff.rdata;

  // ************************************************************
  // checks
  // ************************************************************
  a_dog_flag_clr: assert property (@(posedge core_clk) disable iff (!srst_n)
    dog_timeout && !sleeping && !cold_evt && !bo_evt |=> !st_ff.cause[RCS_B_DOG] && !st_ff.tmo_n)
    else $error("watchdog reset did not clear its flags");
  a_ri_flag_clr: assert property (@(posedge core_clk) disable iff (!srst_n)
    soft_reset_instr && !cold_evt && !bo_evt |=> !st_ff.cause[RCS_B_RI] && !core_rst_n)
    else $error("reset instruction flag not cleared");
  a_pin_hold_rst: assert property (@(posedge core_clk) disable iff (!srst_n)
    pin_low |=> !core_rst_n)
    else $error("pin low did not hold reset");
  a_por_flags: assert property (@(posedge core_clk) disable iff (!srst_n)
    cold_evt |=> st_ff.cause == RCS_CAUSE_RST && st_ff.tmo_n && st_ff.sleep_n)
    else $error("power-on flags wrong");
  a_bor_flags: assert property (@(posedge core_clk) disable iff (!srst_n)
    bo_evt && !cold_evt |=> !st_ff.cause[RCS_B_BOR] && !st_ff.cause[RCS_B_OVF] && !st_ff.cause[RCS_B_UNF])
    else $error("brown-out flags wrong");
  a_bit5_zero: assert property (@(posedge core_clk) disable iff (!srst_n)
    reg_rd && reg_addr == RCS_ADDR_CAUSE |=> !reg_rdata[5])
    else $error("cause bit 5 not zero");
  a_stk_flag_set: assert property (@(posedge core_clk) disable iff (!srst_n)
    stack_overflow && !cold_evt && !bo_evt |=> st_ff.cause[RCS_B_OVF])
    else $error("overflow flag not set");
  a_pin_release: assert property (@(posedge core_clk) disable iff (!srst_n)
    $rose(st_ff.run) |-> pc_load && pc_value == RCS_PC_RESET && $past(st_ff.dly_done, 10))
    else $error("start before delay done");
  a_wake_pc: assert property (@(posedge core_clk) disable iff (!srst_n)
    st_ff.run && sleeping && wake_irq && !wake_dog && !warm_rst && !pin_low && !cold_evt && !bo_evt
    |=> pc_load && (push_return == $past(global_irq_enable)))
    else $error("wake-up pc handling wrong");

  // pin lets go after the delay is over: ten quiet edges, then the core starts
  sequence s_pin_up;
    $fell(pin_low) && st_ff.dly_done && !warm_rst && !cold_evt && !bo_evt;
  endsequence
  sequence s_quiet;
    !pin_low && !warm_rst && !cold_evt && !bo_evt;
  endsequence
  sequence s_core_start;
    !core_rst_n ##1 (core_rst_n && pc_load && pc_value == RCS_PC_RESET);
  endsequence

  a_ten_cycle_start: assert property (@(posedge core_clk) disable iff (!srst_n)
    s_pin_up ##1 s_quiet [*8] ##1 s_quiet |-> s_core_start)
    else $error("start not ten cycles after pin release");
  a_delay_select: assert property (@(posedge core_clk) disable iff (!srst_n)
    cold_evt || bo_evt |=> st_ff.dly_done == $past(powerup_delay_enable_n) && !core_rst_n)
    else $error("power-up delay selection wrong");
  a_delay_hold: assert property (@(posedge core_clk) disable iff (!srst_n)
    !st_ff.dly_done |-> !core_rst_n)
    else $error("core released while power-up delay runs");
  a_delay_length: assert property (@(posedge core_clk) disable iff (!srst_n)
    $rose(st_ff.dly_done) && !$past(cold_evt) && !$past(bo_evt) |-> st_ff.dly_cnt == RCS_CNT_W'(PWRUP_CYC - 1))
    else $error("power-up delay length wrong");
  a_pin_flag_clr: assert property (@(posedge core_clk) disable iff (!srst_n)
    pin_low && !cold_evt && !bo_evt |=> !st_ff.cause[RCS_B_PIN])
    else $error("pin reset did not clear its flag");
  a_lp_bor_flag: assert property (@(posedge core_clk) disable iff (!srst_n)
    low_power_brownout |=> !st_ff.cause[RCS_B_BOR])
    else $error("low-power brown-out flag not cleared");
  a_stk_no_rst: assert property (@(posedge core_clk) disable iff (!srst_n)
    core_rst_n && !stack_fault_reset_enable && !dog_timeout && !soft_reset_instr && !pin_low
    && !cold_evt && !bo_evt |=> core_rst_n)
    else $error("stack fault reset without enable");
  a_wake_dog_bits: assert property (@(posedge core_clk) disable iff (!srst_n)
    sleeping && wake_dog && !pin_low && !cold_evt && !bo_evt |=> !st_ff.tmo_n && !st_ff.sleep_n)
    else $error("watchdog wake status bits wrong");
  a_cause_keep: assert property (@(posedge core_clk) disable iff (!srst_n)
    dog_timeout && !sleeping && !reg_wr && !soft_reset_instr && !pin_low && !stack_overflow
    && !stack_underflow && !cold_evt && !bo_evt
    |=> $stable({st_ff.cause[RCS_B_OVF], st_ff.cause[RCS_B_UNF], st_ff.cause[RCS_B_PIN], st_ff.cause[RCS_B_RI]}))
    else $error("watchdog reset changed other cause bits");

endmodule : rcs_top

/* tb/rcs_core_model.sv */
/*
  Stand-in for the processor core beside the reset sequencer: keeps a program
  counter and the last pushed return address.
  Assumes pc_load, pc_value and push_return are registered outputs of rcs_top.
*/
`timescale 1ns/1ps
module rcs_core_model
  import rcs_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                core_rst_n,
  input  wire logic                sleeping,
  input  wire logic                pc_load,
  input  wire logic [RCS_PC_W-1:0] pc_value,
  input  wire logic                push_return,
  output logic      [RCS_PC_W-1:0] cur_pc,
  output logic      [RCS_PC_W-1:0] ret_pc
);
  // pc frozen in reset and sleep so the wake target stays predictable
  always_ff @(posedge core_clk)
  begin
    if (pc_load)
      cur_pc <= pc_value;
    else if (core_rst_n && !sleeping)
      cur_pc <= cur_pc + RCS_PC_ONE;
    if (push_return)
      ret_pc <= cur_pc + RCS_PC_ONE;
  end
endmodule : rcs_core_model

/* tb/rcs_top_tb_top.sv */
/*
  Self-checking bench for rcs_top: reset sources, start-up timing, cause flags,
  wake-up targets and register access.
  Assumes rcs_pkg, rcs_top and rcs_core_model are compiled before this file.
*/
`timescale 1ns/1ps
`define RCS_CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module rcs_top_tb_top
  import rcs_pkg::*;
();
  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam int PWR = 20;
  logic                core_clk = 1'b0;
  logic                rstn, ext_reset_pin, ext_reset_enable, powerup_delay_enable_n;
  logic                stack_fault_reset_enable, sleeping, global_irq_enable, brownout_ready;
  logic                reg_wr, reg_rd, core_rst_n, pc_load, push_return;
  logic [7:0]          src, reg_wdata, reg_rdata, cause, stat, bc, d;
  logic [1:0]          wk, ins, reg_addr, a;
  logic [RCS_PC_W-1:0] cur_pc, ret_pc, pc_value, pc0;
  int                  bad_count, num_checks, lo;

  always #5 core_clk = ~core_clk;

  rcs_top #(.PWRUP_CYC(PWR)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .por_evt(src[0]), .bor_evt(src[1]),
    .low_power_brownout(src[2]), .prog_exit(src[3]), .ext_reset_pin(ext_reset_pin),
    .ext_reset_enable(ext_reset_enable), .powerup_delay_enable_n(powerup_delay_enable_n),
    .stack_fault_reset_enable(stack_fault_reset_enable), .dog_timeout(src[4]),
    .soft_reset_instr(src[5]), .stack_overflow(src[7]), .stack_underflow(src[6]),
    .sleeping(sleeping), .wake_dog(wk[1]), .wake_irq(wk[0]), .global_irq_enable(global_irq_enable),
    .watchdog_clear_instr(ins[0]), .sleep_instr(ins[1]), .brownout_ready(brownout_ready),
    .cur_pc(cur_pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_rst_n(core_rst_n), .pc_load(pc_load), .pc_value(pc_value),
    .push_return(push_return));

  rcs_core_model u_core (
    .core_clk(core_clk), .core_rst_n(core_rst_n), .sleeping(sleeping), .pc_load(pc_load),
    .pc_value(pc_value), .push_return(push_return), .cur_pc(cur_pc), .ret_pc(ret_pc));

  // ************************************************************
  // tasks and expectations
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] ad, input logic [7:0] dv);
    reg_addr  <= ad;
    reg_wdata <= dv;
    reg_wr    <= 1'b1;
    tick(1);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] ad, input logic [7:0] e);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    tick(1);
    reg_rd   <= 1'b0;
    `RCS_CHK(reg_rdata, e)
    tick(1);
    `RCS_CHK(reg_rdata, 8'h00)
  endtask : rd

  task automatic fire(input int k);
    src[k] <= 1'b1;
    tick(1);
    src[k] <= 1'b0;
    `RCS_CHK(core_rst_n, 1'b0)
  endtask : fire

  task automatic instr(input int i);
    ins[i] <= 1'b1;
    tick(1);
    ins[i] <= 1'b0;
  endtask : instr

  task automatic hold(input int n, input logic v);
    repeat (n)
    begin
      tick(1);
      `RCS_CHK(core_rst_n, v)
    end
  endtask : hold

  task automatic run_wait(input int lw, input int hi);
    int n;
    n = 0;
    while (core_rst_n !== 1'b1 && n < hi)
    begin
      tick(1);
      n++;
    end
    `RCS_CHK(n >= lw && n < hi, 1'b1)
    `RCS_CHK({pc_load, pc_value}, {1'b1, RCS_PC_RESET})
  endtask : run_wait

  // kinds: 0 power-on, 1 brown-out, 2 low-power brown-out, 3 program exit,
  // 4 watchdog, 5 reset instruction, 6 stack underflow, 7 stack overflow
  function automatic logic [7:0] exp_cause(input int k, input logic [7:0] c);
    case (k)
      0, 3: return 8'h1c;
      1, 2: return (c & 8'h06) | 8'h18;
      4: return c & 8'hef;
      5: return c & 8'hfb;
      6: return c | 8'h40;
      default: return c | 8'h80;
    endcase
  endfunction : exp_cause

  function automatic logic [7:0] exp_stat(input int k, input logic [7:0] s);
    case (k)
      0, 3: return 8'h18;
      1, 2: return s | 8'h18;
      4: return s & 8'hef;
      default: return s;
    endcase
  endfunction : exp_stat

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ************************************************************
  // sequence
  // ************************************************************
  // about 650 cycles expected; some thirty times that before giving up
  initial
  begin
    #200_000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h44bd4451));
    {rstn, src, wk, ins, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ext_reset_enable, stack_fault_reset_enable, sleeping, global_irq_enable, brownout_ready} = '0;
    ext_reset_pin = 1'b1;
    powerup_delay_enable_n = 1'b1;
    tick(20);
    rstn <= 1'b1;
    run_wait(9, 20);
    rd(RCS_ADDR_CAUSE, 8'h1c);
    rd(RCS_ADDR_STATUS, 8'h18);
    rd(RCS_ADDR_BORCTL, 8'h80);
    wr(RCS_ADDR_CAUSE, 8'hff);
    rd(RCS_ADDR_CAUSE, 8'hdf);
    cause = 8'hdf;
    stat = 8'h18;
    bc = 8'h80;
    repeat (12)
    begin
      a = 2'($urandom_range(3));
      d = 8'($urandom);
      brownout_ready <= 1'($urandom);
      wr(a, d);
      if (a == 2'h0)
        cause = d & 8'hdf;
      if (a == 2'h1)
        bc = d & 8'hc0;
      if (a == 2'h2)
        stat = (stat & 8'h18) | (d & 8'h07);
      rd(a, a == 2'h0 ? cause : a == 2'h1 ? bc | {7'h0, brownout_ready} : a == 2'h2 ? stat : 8'h00);
    end
    stack_fault_reset_enable <= 1'b1;
    for (int pass = 0; pass < 2; pass++)
      for (int k = 0; k < 8; k++)
      begin
        powerup_delay_enable_n <= pass[0];
        cause = 8'($urandom) & 8'hdf;
        wr(RCS_ADDR_CAUSE, cause);
        instr(0);
        stat = stat | 8'h18;
        fire(k);
        lo = (k < 4 && pass == 0) ? PWR : 9;
        run_wait(lo, lo + 16);
        rd(RCS_ADDR_CAUSE, exp_cause(k, cause));
        rd(RCS_ADDR_STATUS, exp_stat(k, stat));
        cause = exp_cause(k, cause);
        stat = exp_stat(k, stat);
      end
    stack_fault_reset_enable <= 1'b0;
    wr(RCS_ADDR_CAUSE, 8'h00);
    src[7] <= 1'b1;
    hold(12, 1'b1);
    src[7] <= 1'b0;
    rd(RCS_ADDR_CAUSE, 8'h80);
    ext_reset_pin <= 1'b0;
    hold(5, 1'b1);
    for (int s = 0; s < 3; s++)
    begin
      ext_reset_pin <= 1'b1;
      ext_reset_enable <= 1'b1;
      cause = 8'($urandom) & 8'hdf;
      wr(RCS_ADDR_CAUSE, cause);
      instr(0);
      stat = stat | 8'h18;
      sleeping <= (s == 1);
      powerup_delay_enable_n <= (s != 2);
      if (s == 2)
        fire(0);
      ext_reset_pin <= 1'b0;
      hold(2 * PWR, 1'b0);
      ext_reset_pin <= 1'b1;
      sleeping <= 1'b0;
      run_wait(9, 14);
      if (s < 2)
      begin
        stat = (s == 1) ? (stat & 8'he7) | 8'h10 : stat;
        rd(RCS_ADDR_CAUSE, cause & 8'hf7);
        rd(RCS_ADDR_STATUS, stat);
      end
    end
    stat = 8'h18;
    wr(RCS_ADDR_CAUSE, cause);
    for (int w = 0; w < 3; w++)
    begin
      global_irq_enable <= (w == 0);
      instr(1);
      stat = (stat & 8'h07) | 8'h10;
      rd(RCS_ADDR_STATUS, stat);
      sleeping <= 1'b1;
      tick(2);
      pc0 = cur_pc;
      wk[w == 2] <= 1'b1;
      tick(1);
      wk <= 2'b00;
      `RCS_CHK({pc_load, push_return, pc_value}, {1'b1, w == 0, w == 0 ? RCS_PC_VECTOR : pc0 + RCS_PC_ONE})
      sleeping <= 1'b0;
      tick(1);
      if (w == 0)
        `RCS_CHK(ret_pc, pc0 + RCS_PC_ONE)
      stat = (w == 2) ? stat & 8'h07 : stat;
      rd(RCS_ADDR_STATUS, stat);
      rd(RCS_ADDR_CAUSE, cause);
    end
    complete_run();
  end
endmodule : rcs_top_tb_top
